// >>> logic/lec_ctrl_one.sv
// Lookup engine control register one with its filtering and flush control
`timescale 1ns/1ns
module lec_ctrl_one #(
  parameter int NPORTS = lec_pkg::LEC_NPORTS
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Management register access
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_q,
  output logic reg_rvalid_q,
  // Settings held in neighbouring registers
  input wire logic [1:0] flush_scope,
  input wire logic [NPORTS-1:0] port_self_filt_en,
  input wire logic [47:0] switch_mac,
  // Received frame source check
  input wire logic pkt_valid,
  input wire logic [$clog2(NPORTS)-1:0] pkt_port,
  input wire logic [47:0] pkt_sa,
  output logic pkt_done_q,
  output logic pkt_drop_q,
  output logic learn_grant_q,
  // Aging controls
  output logic aging_en_q,
  output logic fast_aging_q,
  // Port link state, asynchronous
  input wire logic [NPORTS-1:0] link_up,
  // Table engine flush handshake
  output logic flush_req_q,
  output lec_pkg::lec_flush_kind_t flush_kind_q,
  output logic flush_dyn_q,
  output logic flush_stat_q,
  output logic [NPORTS-1:0] flush_ports_q,
  input wire logic flush_done
);
  import lec_pkg::*;

  logic [7:0] ctl_q;
  logic [NPORTS-1:0] link_s1_q, link_s2_q, link_prev_q;
  logic hit, wr_hit, rd_hit;
  logic start_all, start_mstp;
  logic [NPORTS-1:0] link_fall, start_link;
  logic busy_all, busy_mstp, seq_idle;
  logic [7:0] rd_value;
  logic sa_mcast, sa_self, port_en, drop_self, drop_mcast;

  assign hit = reg_addr == LEC_CTRL1_ADDR;
  assign wr_hit = reg_wr && hit;
  assign rd_hit = reg_rd && hit;
  assign start_all = wr_hit && reg_wdata[LEC_B_FLUSH_ALL];
  assign start_mstp = wr_hit && reg_wdata[LEC_B_FLUSH_MSTP];

  // Trigger bits show the flush in progress instead of a stored value
  always_comb begin
    rd_value = ctl_q;
    rd_value[LEC_B_FLUSH_ALL] = busy_all;
    rd_value[LEC_B_FLUSH_MSTP] = busy_mstp;
  end

  // Trigger bits are not stored; the sequencer holds them until the flush ends
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctl_q <= LEC_CTRL1_RST;
    end else if (wr_hit) begin
      ctl_q <= reg_wdata & ~(8'h01 << LEC_B_FLUSH_ALL) & ~(8'h01 << LEC_B_FLUSH_MSTP);
    end
  end

  // Unmapped addresses read as zero
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      reg_rdata_q <= 8'h00;
      reg_rvalid_q <= 1'b0;
    end else begin
      reg_rvalid_q <= reg_rd;
      reg_rdata_q <= rd_hit ? rd_value : 8'h00;
    end
  end

  assign aging_en_q = ctl_q[LEC_B_AGING];
  assign fast_aging_q = ctl_q[LEC_B_FAST_AGE];

  // Source address filtering
  assign sa_mcast = pkt_sa[LEC_MCAST_BIT];
  assign sa_self = pkt_sa == switch_mac;
  assign port_en = port_self_filt_en[pkt_port];
  assign drop_self = ctl_q[LEC_B_SELF_FILT] && port_en && sa_self;
  assign drop_mcast = !ctl_q[LEC_B_MCAST_FWD] && sa_mcast;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pkt_done_q <= 1'b0;
      pkt_drop_q <= 1'b0;
      learn_grant_q <= 1'b0;
    end else begin
      pkt_done_q <= pkt_valid;
      pkt_drop_q <= pkt_valid && (drop_self || drop_mcast);
      // Dropped and multicast sources are never learned
      learn_grant_q <= pkt_valid && !ctl_q[LEC_B_LEARN_DIS] && !sa_mcast
        && !drop_self;
    end
  end

  // Link state crosses in from the PHYs; only the second stage and its one-cycle delayed copy are looked at
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      link_s1_q <= '0;
      link_s2_q <= '0;
      link_prev_q <= '0;
    end else begin
      link_s1_q <= link_up;
      link_s2_q <= link_s1_q;
      link_prev_q <= link_s2_q;
    end
  end

  assign link_fall = link_prev_q & ~link_s2_q;
  assign start_link = ctl_q[LEC_B_LINK_FLUSH] ? link_fall : '0;

  lec_flush_seq #(
    .NPORTS(NPORTS)
  ) u_seq (
    .clk_sys(clk_sys),
    .reset(reset),
    .start_all(start_all),
    .start_mstp(start_mstp),
    .start_link(start_link),
    .flush_scope(flush_scope),
    .flush_req_q(flush_req_q),
    .flush_kind_q(flush_kind_q),
    .flush_dyn_q(flush_dyn_q),
    .flush_stat_q(flush_stat_q),
    .flush_ports_q(flush_ports_q),
    .flush_done(flush_done),
    .busy_all(busy_all),
    .busy_mstp(busy_mstp),
    .idle(seq_idle)
  );

  // Checks
  sequence s_all_written;
    wr_hit && reg_wdata[LEC_B_FLUSH_ALL] && seq_idle && flush_scope != LEC_SCOPE_NONE;
  endsequence

  sequence s_all_issued;
    ##2 (flush_req_q && flush_kind_q == LEC_FL_ALL);
  endsequence

  a_learn_block: assert property (@(posedge clk_sys) disable iff (reset)
    (pkt_valid && ctl_q[LEC_B_LEARN_DIS]) |=> !learn_grant_q)
    else $error("learning granted while disabled");

  a_self_drop: assert property (@(posedge clk_sys) disable iff (reset)
    (pkt_valid && sa_self && port_en && ctl_q[LEC_B_SELF_FILT]) |=> pkt_drop_q)
    else $error("self-addressed frame not dropped");

  a_self_off: assert property (@(posedge clk_sys) disable iff (reset)
    (pkt_valid && !ctl_q[LEC_B_SELF_FILT] && !sa_mcast) |=> !pkt_drop_q)
    else $error("frame dropped with filters off");

  a_flush_all_start: assert property (@(posedge clk_sys) disable iff (reset)
    s_all_written |-> s_all_issued)
    else $error("table flush not issued");

  a_mstp_read: assert property (@(posedge clk_sys) disable iff (reset)
    (wr_hit && reg_wdata[LEC_B_FLUSH_MSTP] && flush_scope != LEC_SCOPE_NONE
      && !flush_done) ##1 rd_hit |=> reg_rdata_q[LEC_B_FLUSH_MSTP])
    else $error("spanning-tree flush not visible");

  a_scope_none: assert property (@(posedge clk_sys) disable iff (reset)
    (flush_req_q && flush_kind_q != LEC_FL_LINK) |-> (flush_dyn_q || flush_stat_q))
    else $error("flush issued with empty scope");

  a_mcast_drop: assert property (@(posedge clk_sys) disable iff (reset)
    (pkt_valid && sa_mcast && !ctl_q[LEC_B_MCAST_FWD]) |=> pkt_drop_q && !learn_grant_q)
    else $error("multicast source not dropped");

  a_aging_write: assert property (@(posedge clk_sys) disable iff (reset)
    wr_hit |=> aging_en_q == $past(reg_wdata[LEC_B_AGING]))
    else $error("aging enable not updated");

  a_fast_write: assert property (@(posedge clk_sys) disable iff (reset)
    wr_hit |=> fast_aging_q == $past(reg_wdata[LEC_B_FAST_AGE]))
    else $error("fast aging not updated");

  a_link_kind: assert property (@(posedge clk_sys) disable iff (reset)
    (flush_req_q && flush_kind_q == LEC_FL_LINK) |-> flush_dyn_q && !flush_stat_q
      && (|flush_ports_q))
    else $error("link flush malformed");

  // A lone spanning-tree trigger reaches the table two cycles after the write
  sequence s_mstp_written;
    wr_hit && reg_wdata[LEC_B_FLUSH_MSTP] && !reg_wdata[LEC_B_FLUSH_ALL] && seq_idle
      && flush_scope != LEC_SCOPE_NONE;
  endsequence

  sequence s_mstp_issued;
    ##2 (flush_req_q && flush_kind_q == LEC_FL_MSTP && flush_ports_q == '1);
  endsequence

  // Register triggers outrank link-down, so only a quiet cycle has a fixed answer time
  sequence s_link_fell;
    (|start_link) && seq_idle && !start_all && !start_mstp;
  endsequence

  sequence s_link_issued;
    ##2 (flush_req_q && flush_kind_q == LEC_FL_LINK && flush_ports_q == $past(start_link, 2));
  endsequence

  a_mstp_start: assert property (@(posedge clk_sys) disable iff (reset)
    s_mstp_written |-> s_mstp_issued)
    else $error("spanning-tree flush not issued");

  a_link_flush: assert property (@(posedge clk_sys) disable iff (reset)
    s_link_fell |-> s_link_issued)
    else $error("link-down flush not issued");

  a_trig_idle: assert property (@(posedge clk_sys) disable iff (reset)
    (seq_idle && !wr_hit) ##1 rd_hit |=> !reg_rdata_q[LEC_B_FLUSH_ALL]
      && !reg_rdata_q[LEC_B_FLUSH_MSTP])
    else $error("trigger bit stuck after flush");

  a_mcast_keep: assert property (@(posedge clk_sys) disable iff (reset)
    (pkt_valid && sa_mcast && ctl_q[LEC_B_MCAST_FWD] && !drop_self) |=> !pkt_drop_q)
    else $error("multicast source dropped while forwarding");

  a_learn_on: assert property (@(posedge clk_sys) disable iff (reset)
    (pkt_valid && !ctl_q[LEC_B_LEARN_DIS] && !sa_mcast && !drop_self) |=> learn_grant_q)
    else $error("unicast learning withheld");
endmodule // lec_ctrl_one

// >>> logic/lec_pkg.sv
// Constants and types for lookup engine control register one
package lec_pkg;
  localparam logic [15:0] LEC_CTRL1_ADDR = 16'h0311;
  localparam logic [7:0] LEC_CTRL1_RST = 8'h0C;
  localparam int LEC_B_LEARN_DIS = 7;
  localparam int LEC_B_SELF_FILT = 6;
  localparam int LEC_B_FLUSH_ALL = 5;
  localparam int LEC_B_FLUSH_MSTP = 4;
  localparam int LEC_B_MCAST_FWD = 3;
  localparam int LEC_B_AGING = 2;
  localparam int LEC_B_FAST_AGE = 1;
  localparam int LEC_B_LINK_FLUSH = 0;
  // Group bit of the first octet of a MAC address
  localparam int LEC_MCAST_BIT = 40;
  localparam int LEC_NPORTS = 7;
  localparam logic [1:0] LEC_SCOPE_NONE = 2'h0;
  localparam logic [1:0] LEC_SCOPE_DYN = 2'h1;
  localparam logic [1:0] LEC_SCOPE_STAT = 2'h2;
  localparam logic [1:0] LEC_SCOPE_BOTH = 2'h3;

  typedef enum logic [1:0] {LEC_FL_ALL, LEC_FL_MSTP, LEC_FL_LINK} lec_flush_kind_t;

  function automatic logic lec_scope_dyn(input logic [1:0] scope);
    return scope == LEC_SCOPE_DYN || scope == LEC_SCOPE_BOTH;
  endfunction

  function automatic logic lec_scope_stat(input logic [1:0] scope);
    return scope == LEC_SCOPE_STAT || scope == LEC_SCOPE_BOTH;
  endfunction
endpackage

// >>> logic/lec_flush_seq.sv
// Flush sequencer: queues flush triggers and hands them one at a time to the table
`timescale 1ns/1ns
module lec_flush_seq #(
  parameter int NPORTS = lec_pkg::LEC_NPORTS
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Triggers
  input wire logic start_all,
  input wire logic start_mstp,
  input wire logic [NPORTS-1:0] start_link,
  input wire logic [1:0] flush_scope,
  // Table engine handshake
  output logic flush_req_q,
  output lec_pkg::lec_flush_kind_t flush_kind_q,
  output logic flush_dyn_q,
  output logic flush_stat_q,
  output logic [NPORTS-1:0] flush_ports_q,
  input wire logic flush_done,
  // Status
  output logic busy_all,
  output logic busy_mstp,
  output logic idle
);
  import lec_pkg::*;

  typedef enum {LEC_SQ_IDLE, LEC_SQ_RUN} lec_seq_state_t;

  lec_seq_state_t state_q;
  logic pend_all_q;
  logic pend_mstp_q;
  logic [NPORTS-1:0] pend_link_q;
  logic take_all, take_mstp, take_link, issue, skip;

  // Fixed priority: whole table, then spanning tree, then link-down ports
  assign take_all = state_q == LEC_SQ_IDLE && pend_all_q;
  assign take_mstp = state_q == LEC_SQ_IDLE && !pend_all_q && pend_mstp_q;
  assign take_link = state_q == LEC_SQ_IDLE && !pend_all_q && !pend_mstp_q && |pend_link_q;
  // Scope 00 finishes a whole-table or spanning-tree flush at once without touching the table
  assign skip = (take_all || take_mstp) && flush_scope == LEC_SCOPE_NONE;
  assign issue = (take_all || take_mstp || take_link) && !skip;

  assign busy_all = pend_all_q || (state_q == LEC_SQ_RUN && flush_kind_q == LEC_FL_ALL);
  assign busy_mstp = pend_mstp_q || (state_q == LEC_SQ_RUN && flush_kind_q == LEC_FL_MSTP);
  assign idle = state_q == LEC_SQ_IDLE && !pend_all_q && !pend_mstp_q && !(|pend_link_q);

  // New trigger wins over the clear of the same pending flag
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pend_all_q <= 1'b0;
      pend_mstp_q <= 1'b0;
      pend_link_q <= '0;
    end else begin
      pend_all_q <= (pend_all_q && !take_all) || start_all;
      pend_mstp_q <= (pend_mstp_q && !take_mstp) || start_mstp;
      pend_link_q <= (take_link ? '0 : pend_link_q) | start_link;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_q <= LEC_SQ_IDLE;
      flush_req_q <= 1'b0;
      flush_kind_q <= LEC_FL_ALL;
      flush_dyn_q <= 1'b0;
      flush_stat_q <= 1'b0;
      flush_ports_q <= '0;
    end else begin
      flush_req_q <= issue;
      case (state_q)
        LEC_SQ_IDLE: begin
          if (issue) begin
            state_q <= LEC_SQ_RUN;
            flush_kind_q <= take_all ? LEC_FL_ALL : (take_mstp ? LEC_FL_MSTP : LEC_FL_LINK);
            // Link-down flush clears learned entries only
            flush_dyn_q <= take_link ? 1'b1 : lec_scope_dyn(flush_scope);
            flush_stat_q <= take_link ? 1'b0 : lec_scope_stat(flush_scope);
            flush_ports_q <= take_link ? pend_link_q : '1;
          end
        end
        LEC_SQ_RUN: begin
          if (flush_done) begin
            state_q <= LEC_SQ_IDLE;
          end
        end
        default: begin
          state_q <= LEC_SQ_IDLE;
        end
      endcase
    end
  end

  a_busy_hold: assert property (@(posedge clk_sys) disable iff (reset)
    (state_q == LEC_SQ_RUN && !flush_done) |=> state_q == LEC_SQ_RUN)
    else $error("flush ended without done");

  a_scope_map: assert property (@(posedge clk_sys) disable iff (reset)
    (issue && !take_link) |=> flush_dyn_q == $past(flush_scope[0])
      && flush_stat_q == $past(flush_scope[1]))
    else $error("flush scope decoded wrongly");
endmodule // lec_flush_seq

// >>> bench/test_lec_ctrl_one.sv
// Self-checking testbench for lookup engine control register one
`timescale 1ns/1ns
module test_lec_ctrl_one;
  import lec_pkg::*;
  logic clk_sys = 0;
  logic reset = 1;
  logic reg_wr = 0;
  logic reg_rd = 0;
  logic pkt_valid = 0;
  logic flush_done = 0;
  logic [15:0] reg_addr = LEC_CTRL1_ADDR;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata_q;
  logic [7:0] rd_v;
  logic reg_rvalid_q, pkt_done_q, pkt_drop_q, learn_grant_q, aging_en_q, fast_aging_q;
  logic [1:0] flush_scope = 2'h1;
  logic [LEC_NPORTS-1:0] port_self_filt_en = 7'h05;
  logic [LEC_NPORTS-1:0] link_up = 7'h7F;
  logic [LEC_NPORTS-1:0] flush_ports_q;
  logic [47:0] switch_mac = 48'h0000_1234_5678;
  logic [47:0] pkt_sa = 48'h0;
  logic [2:0] pkt_port = 3'h0;
  logic flush_req_q, flush_dyn_q, flush_stat_q;
  lec_flush_kind_t flush_kind_q;
  int n_fail = 0;
  int checks = 0;
  int n_req;

  lec_ctrl_one u_lec_ctrl_one (
    .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
    .flush_scope(flush_scope), .port_self_filt_en(port_self_filt_en), .switch_mac(switch_mac),
    .pkt_valid(pkt_valid), .pkt_port(pkt_port), .pkt_sa(pkt_sa), .pkt_done_q(pkt_done_q),
    .pkt_drop_q(pkt_drop_q), .learn_grant_q(learn_grant_q), .aging_en_q(aging_en_q),
    .fast_aging_q(fast_aging_q), .link_up(link_up), .flush_req_q(flush_req_q),
    .flush_kind_q(flush_kind_q), .flush_dyn_q(flush_dyn_q), .flush_stat_q(flush_stat_q),
    .flush_ports_q(flush_ports_q), .flush_done(flush_done)
  );

  initial begin
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic finish_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  // All drivers enter and leave at a falling edge
  task automatic wr(input logic [7:0] d);
    reg_addr = LEC_CTRL1_ADDR;
    reg_wdata = d;
    reg_wr = 1;
    @(negedge clk_sys) reg_wr = 0;
  endtask

  task automatic rd(input logic [15:0] a);
    reg_addr = a;
    reg_rd = 1;
    @(negedge clk_sys) reg_rd = 0;
    rd_v = (reg_rvalid_q === 1'b1) ? reg_rdata_q : 8'hEE;
  endtask

  task automatic pkt(input logic [2:0] p, input logic [47:0] sa, input logic dr, input logic gr);
    pkt_port = p;
    pkt_sa = sa;
    pkt_valid = 1;
    @(negedge clk_sys) pkt_valid = 0;
    chk("pkt_done", pkt_done_q, 1);
    chk("pkt_drop", pkt_drop_q, dr);
    chk("learn_grant", learn_grant_q, gr);
    // Idle cycle so back-to-back frames never drop and raise valid in one step
    @(negedge clk_sys);
  endtask

  task automatic cnt_req(input int n);
    n_req = 0;
    repeat (n) begin
      @(negedge clk_sys);
      if (flush_req_q === 1'b1) n_req++;
    end
  endtask

  // Waits for one flush command, checks it, then lets the table engine finish it
  task automatic flush(input lec_flush_kind_t k, input logic dy, input logic st,
      input logic [6:0] pm);
    for (int i = 0; i < 20 && flush_req_q !== 1'b1; i++) @(negedge clk_sys);
    chk("flush_req", flush_req_q, 1);
    chk("flush_kind", flush_kind_q, k);
    chk("flush_dyn", flush_dyn_q, dy);
    chk("flush_stat", flush_stat_q, st);
    chk("flush_ports", flush_ports_q, pm);
    repeat (3) @(negedge clk_sys);
    flush_done = 1;
    @(negedge clk_sys) flush_done = 0;
    @(negedge clk_sys);
  endtask

  task automatic t_reset;
    rd(LEC_CTRL1_ADDR);
    chk("ctrl reset", rd_v, 8'h0C);
    chk("aging_en", aging_en_q, 1);
    chk("fast_aging", fast_aging_q, 0);
    pkt(3'h0, switch_mac, 0, 1);
    rd(16'h0310);
    chk("unmapped", rd_v, 8'h00);
  endtask

  task automatic t_bits;
    wr(8'hC2);
    rd(LEC_CTRL1_ADDR);
    chk("ctrl", rd_v, 8'hC2);
    chk("aging_en", aging_en_q, 0);
    chk("fast_aging", fast_aging_q, 1);
    pkt(3'h0, switch_mac, 1, 0);
    pkt(3'h1, switch_mac, 0, 0);
    pkt(3'h2, 48'h0000_0000_0042, 0, 0);
    pkt(3'h1, 48'h0100_0000_0042, 1, 0);
    wr(8'h08);
    pkt(3'h0, switch_mac, 0, 1);
    pkt(3'h1, 48'h0100_0000_0042, 0, 0);
  endtask

  // Both triggers at once: whole table first, then the spanning-tree entries
  task automatic t_flush;
    for (int s = 1; s < 4; s++) begin
      flush_scope = s[1:0];
      wr(8'h38);
      rd(LEC_CTRL1_ADDR);
      chk("trig busy", rd_v, 8'h38);
      flush(LEC_FL_ALL, s[0], s[1], 7'h7F);
      flush(LEC_FL_MSTP, s[0], s[1], 7'h7F);
      rd(LEC_CTRL1_ADDR);
      chk("trig done", rd_v, 8'h08);
    end
    wr(8'h18);
    flush(LEC_FL_MSTP, 1, 1, 7'h7F);
    flush_scope = 2'h0;
    wr(8'h28);
    cnt_req(6);
    chk("scope none req", n_req, 0);
    rd(LEC_CTRL1_ADDR);
    chk("scope none bit", rd_v, 8'h08);
  endtask

  task automatic t_link;
    wr(8'h09);
    link_up[2] = 0;
    flush(LEC_FL_LINK, 1, 0, 7'h04);
    link_up[2] = 1;
    wr(8'h08);
    link_up[3] = 0;
    cnt_req(12);
    chk("link flush off", n_req, 0);
  endtask

  initial begin
    repeat (10) @(negedge clk_sys);
    reset = 0;
    t_reset;
    t_bits;
    t_flush;
    t_link;
    finish_test;
  end

  // Whole run needs well under a thousand cycles
  initial begin
    #(5000 * 50);
    n_fail++;
    finish_test;
  end
endmodule // test_lec_ctrl_one
